/* File: hdl/lock_forwarding.v */
/*
  Downstream lock forwarding for an upstream-to-card bridge path: routes the upstream lock
  from multifunction pin four, claims the card lock, holds the locked region, gates write
  posting and decides whether each downstream access must carry the lock.
  Assumes all inputs are synchronous to clk_i and the upstream decoder flags each
  transaction start and end for accesses that target the card.
*/
`include "lock_fwd_map.vh"
module lock_forwarding (
  input  wire                     clk_i,
  input  wire                     rst_n_i,
  input  wire [`MFP4_ROUTE_W-1:0] mfp4_route_i,
  input  wire                     multifunction_pin_four_n_i,
  input  wire                     txn_start_i,
  input  wire                     txn_end_i,
  input  wire [`ADDR_W-1:0]       txn_addr_i,
  input  wire                     card_lock_n_i,
  output reg                      card_lock_n_o,
  output reg                      card_lock_oe_o,
  output reg                      post_en_o,
  output reg                      txn_locked_o,
  output reg                      lock_active_o
);
  reg  [3:0]         state_q;
  reg  [3:0]         state_d;
  reg  [`ADDR_W-1:0] base_q;
  reg                busy_q;
  reg                lock_prev_q;
  wire               lock_routed;
  wire               lock_asserted;
  wire               lock_edge;
  wire               region_hit;

  assign lock_routed   = (mfp4_route_i == `MFP4_ROUTE_LOCK);
  // Card lock input is never looked at: locks from the card stay downstream.
  assign lock_asserted = lock_routed && !multifunction_pin_four_n_i;
  // A new locked sequence starts when lock is low at a start after being high before.
  assign lock_edge     = lock_asserted && !lock_prev_q;

  lock_region_match u_match (
    .addr_i         (txn_addr_i),
    .base_i         (base_q),
    .region_valid_i (state_q != `ST_IDLE),
    .hit_o          (region_hit)
  );

  always @* begin
    state_d = state_q;
    case (state_q)
      `ST_IDLE: begin
        // Grant alone never takes lock; only a start with lock newly asserted does.
        if (txn_start_i && lock_edge) begin
          state_d = `ST_CLAIM;
        end
      end
      `ST_CLAIM: begin
        if (txn_end_i) begin
          state_d = lock_asserted ? `ST_HELD : `ST_IDLE;
        end
      end
      `ST_HELD: begin
        if (!lock_asserted) begin
          state_d = (busy_q && !txn_end_i) ? `ST_DRAIN : `ST_IDLE;
        end
      end
      `ST_DRAIN: begin
        if (txn_end_i) begin
          state_d = `ST_IDLE;
        end
      end
      default: begin
        state_d = `ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q        <= `ST_IDLE;
      base_q         <= {`ADDR_W{1'b0}};
      busy_q         <= 1'b0;
      lock_prev_q    <= 1'b0;
      card_lock_n_o  <= 1'b1;
      card_lock_oe_o <= 1'b0;
      post_en_o      <= 1'b1;
      txn_locked_o   <= 1'b0;
      lock_active_o  <= 1'b0;
    end else begin
      state_q     <= state_d;
      lock_prev_q <= lock_asserted;
      if (txn_start_i) begin
        busy_q <= 1'b1;
      end else if (txn_end_i) begin
        busy_q <= 1'b0;
      end
      if (state_q == `ST_IDLE && txn_start_i && lock_edge) begin
        base_q <= txn_addr_i;
      end
      // Card lock is driven on its own dedicated pin while a lock is forwarded.
      card_lock_oe_o <= (state_d != `ST_IDLE);
      card_lock_n_o  <= !(state_d == `ST_HELD || state_d == `ST_DRAIN ||
                          (state_d == `ST_CLAIM && state_q == `ST_CLAIM));
      post_en_o      <= (state_d == `ST_IDLE);
      lock_active_o  <= (state_d != `ST_IDLE);
      // Accesses outside the region run unlocked, leaving the bus open to others.
      if (txn_start_i) begin
        txn_locked_o <= (state_q == `ST_IDLE) ? lock_edge :
                        (region_hit && lock_asserted);
      end else if (txn_end_i) begin
        txn_locked_o <= 1'b0;
      end
    end
  end
endmodule // lock_forwarding

/* File: hdl/lock_fwd_map.vh */
/*
  Constants for the downstream lock forwarding block: routing code, lock granularity
  and state encodings.
  Assumes inclusion by the bridge lock logic, which runs on the upstream bus clock.
*/
// Functional notes
// - Upstream lock input is taken from multifunction pin four when routing selects it.
// - Locks are forwarded only downstream; card-originated locks never go upstream.
// - Nonexclusive accesses outside the locked region proceed normally while locked.
// - Other initiators may use the bus while one master owns lock.
// - Locked region is a naturally aligned sixteen-byte block.
// - Write posting is disabled throughout a locked operation.
// - Bridge lock behaviour applies equally on the card bridging path.
// - Card-side lock protocol uses the dedicated card lock signal.
// - Device drives card lock to gain exclusive access to the card target.
`ifndef LOCK_FWD_MAP_VH
`define LOCK_FWD_MAP_VH
`define MFP4_ROUTE_W     4
`define MFP4_ROUTE_LOCK  4'h2
`define LOCK_GRAN_BITS   4
`define ADDR_W           32
`define ST_IDLE          4'h1
`define ST_CLAIM         4'h2
`define ST_HELD          4'h4
`define ST_DRAIN         4'h8
`endif

/* File: hdl/lock_region_match.v */
/*
  Compares an access address with the held lock region at sixteen-byte granularity.
  Assumes the region base is valid only while region_valid_i is high.
*/
`include "lock_fwd_map.vh"
module lock_region_match (
  input  wire [`ADDR_W-1:0] addr_i,
  input  wire [`ADDR_W-1:0] base_i,
  input  wire               region_valid_i,
  output wire               hit_o
);
  // Only bits above the granule take part in the compare.
  assign hit_o = region_valid_i &&
                 (addr_i[`ADDR_W-1:`LOCK_GRAN_BITS] == base_i[`ADDR_W-1:`LOCK_GRAN_BITS]);
endmodule // lock_region_match

/* File: tb/card_model.sv */
/* Card target: ends each transaction after wait_i cycles. Assumes a pulled-up lock wire. */
module card_model (
  input  wire logic       clk_i, start_i, lock_n_i, oe_i,
  input  wire logic [3:0] wait_i,
  output logic            end_o = 1'b0,
  output wire logic       wire_n_o
);
  timeunit 1ns; timeprecision 100ps;
  logic [3:0] cnt_q = 4'h0;
  assign wire_n_o = oe_i ? lock_n_i : 1'b1;
  always @(posedge clk_i) begin
    cnt_q <= start_i ? wait_i : cnt_q - {3'h0, cnt_q != 4'h0};
    end_o <= cnt_q == 4'h1;
  end
endmodule // card_model

/* File: tb/lock_fwd_sva.sv */
/* Port checker for lock_forwarding. Assumes one clock domain. */
`include "lock_fwd_map.vh"
module lock_fwd_sva (
  input wire logic clk_i, rst_n_i, multifunction_pin_four_n_i, txn_start_i, txn_end_i,
  input wire logic card_lock_n_i, card_lock_n_o, card_lock_oe_o, post_en_o, txn_locked_o,
  input wire logic lock_active_o,
  input wire logic [`MFP4_ROUTE_W-1:0] mfp4_route_i,
  input wire logic [`ADDR_W-1:0]       txn_addr_i
);
  timeunit 1ns; timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire idle = !lock_active_o;
  wire go = txn_start_i && mfp4_route_i == `MFP4_ROUTE_LOCK;
  a_post_held: assert property (lock_active_o |-> !post_en_o) else $error("post");
  a_post_back: assert property (idle |-> post_en_o && !txn_locked_o) else $error("idle");
  a_oe_match: assert property (card_lock_oe_o == lock_active_o) else $error("oe");
  a_idle_pin: assert property (!card_lock_oe_o |-> card_lock_n_o) else $error("pin");
  a_route_off: assert property (idle && !go |=> idle) else $error("route");
  a_claim_go: assert property (idle && go && $fell(multifunction_pin_four_n_i)
    |=> lock_active_o && txn_locked_o) else $error("claim");
  a_claim_drive: assert property ($rose(lock_active_o) && !txn_end_i
    |=> !card_lock_n_o) else $error("drive");
  a_lock_span: assert property ($fell(txn_locked_o) |-> $past(txn_end_i)) else $error("span");
  c_claim: cover property (go ##1 lock_active_o);
  c_release: cover property ($fell(lock_active_o));
  c_outside: cover property (lock_active_o && txn_start_i ##1 !txn_locked_o);
endmodule // lock_fwd_sva
bind lock_forwarding lock_fwd_sva u_sva (.*);

/* File: tb/tb_top.sv */
/* Random lock tests of lock_forwarding. Assumes card_model at the far side. */
`include "lock_fwd_map.vh"
module tb_top;
  timeunit 1ns; timeprecision 100ps;
  logic clk_i = 1'b0, rst_n_i = 1'b0, pin_n = 1'b1, start = 1'b0, fin, w_n, lk_n, oe, post, lkd, act, s;
  logic [3:0] route = 4'h0, wt = 4'h2;
  logic [31:0] addr = 32'h0, a, base;
  int mismatches = 0, comparisons = 0;
  initial forever #12.5 clk_i = ~clk_i;
  lock_forwarding DUT (.clk_i, .rst_n_i, .mfp4_route_i(route), .multifunction_pin_four_n_i(pin_n),
    .txn_start_i(start), .txn_end_i(fin), .txn_addr_i(addr), .card_lock_n_i(w_n),
    .card_lock_n_o(lk_n), .card_lock_oe_o(oe), .post_en_o(post), .txn_locked_o(lkd),
    .lock_active_o(act));
  card_model u_card (.clk_i, .start_i(start), .lock_n_i(lk_n), .oe_i(oe), .wait_i(wt),
    .end_o(fin), .wire_n_o(w_n));
  task automatic check(input string n, input logic [3:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("%0d checks, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [3:0] same(input logic [31:0] x, y);
    return {3'h0, x[31:4] == y[31:4]};
  endfunction
  // The bench's only initiator is always the lock master, so no arbiter withholds its grants.
  task automatic txn(input logic [31:0] x, input logic fall);
    @(posedge clk_i);
    start <= 1'b1; addr <= x; wt <= 4'($urandom_range(7, 2));
    if (fall) pin_n <= 1'b0;
    @(posedge clk_i) start <= 1'b0;
    @(posedge clk_i) #1 s = lkd;
    for (int i = 0; i < 12 && fin !== 1'b1; i++) @(posedge clk_i);
    @(posedge clk_i) #1;
  endtask
  initial begin
    void'($urandom(47));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) begin
      route <= 4'($urandom) | 4'h1;
      txn($urandom, 1'b1);
      check("refused", {3'h0, act}, 4'h0);
      pin_n <= 1'b1;
    end
    $display("refusal test done");
    route <= `MFP4_ROUTE_LOCK;
    txn($urandom, 1'b0);
    check("grant only", {3'h0, act}, 4'h0);
    base = $urandom;
    txn(base, 1'b1);
    check("first", {3'h0, s}, 4'h1);
    check("held", {act, post, oe, lk_n}, 4'ha);
    check("wire", {3'h0, w_n}, 4'h0);
    for (int k = 0; k < 6; k++) begin
      a = base ^ (k[0] ? 32'($urandom_range(15)) : 32'h10 << k);
      txn(a, 1'b0);
      check("region", {3'h0, s}, same(a, base));
    end
    @(posedge clk_i);
    start <= 1'b1; addr <= base; wt <= 4'h6;
    @(posedge clk_i) start <= 1'b0;
    @(posedge clk_i) pin_n <= 1'b1;
    @(posedge clk_i) #1;
    check("drain", {act, post, oe, lk_n}, 4'ha);
    for (int i = 0; i < 12 && fin !== 1'b1; i++) @(posedge clk_i);
    @(posedge clk_i) #1;
    check("release", {act, post, oe, lk_n}, 4'h5);
    txn(base, 1'b0);
    check("idle", {act, post, oe, lk_n}, 4'h5);
    $display("lock test done");
    close_out();
  end
  initial begin
    #20us mismatches++;
    close_out();
  end
endmodule // tb_top
